// [bench/adi_asserts.sv]
`timescale 1ns/10ps
module adi_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // master drivers
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    // device drivers
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    // resolved lines
    input wire logic scl,
    input wire logic sda
);
    localparam int min_per = 4 * adi_pkg::quarter_cycles;
    logic scl_q, sda_q, rw_q, acked_q;
    logic [3:0] bitn_q;
    logic [1:0] byten_q;
    logic [9:0] per_q;
    wire logic rise = scl && !scl_q;
    wire logic hi = scl && scl_q;
    wire logic start = hi && sda_q && !sda;
    wire logic stop = hi && !sda_q && sda;
    wire logic dev_pull = sda_s_oe && !sda_s_o;
    wire logic m_pull = sda_m_oe && !sda_m_o;
    wire logic last_bit = bitn_q == 4'h9;
    wire logic data_bit = bitn_q inside {[4'h1:4'h8]};
    ////////////////////////////////////////////////////////////////
    // pulse 1 of a byte is skipped by the master hold check: a stop may follow it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rw_q <= 1'b0;
            acked_q <= 1'b0;
            bitn_q <= 4'h0;
            byten_q <= 2'h0;
            per_q <= 10'h3ff;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            per_q <= rise ? 10'h001 : per_q + {9'h000, per_q != 10'h3ff};
            if (start) begin
                bitn_q <= 4'h0;
                byten_q <= 2'h0;
                rw_q <= 1'b0;
                acked_q <= 1'b0;
            end else if (rise) begin
                bitn_q <= last_bit ? 4'h1 : bitn_q + 4'h1;
                byten_q <= byten_q + {1'b0, last_bit};
                rw_q <= (byten_q == 2'h0 && bitn_q == 4'h7) ? sda : rw_q;
                acked_q <= (byten_q == 2'h0 && bitn_q == 4'h8) ? !sda : acked_q;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_dev_high_hold:
        assert property (hi |-> $stable(dev_pull)) else $error("device data moved with clock high");
    a_mst_high_hold:
        assert property (hi && bitn_q > 4'h1 |-> $stable(m_pull)) else $error("master data moved with clock high");
    a_addr_no_drive:
        assert property (hi && byten_q == 2'h0 && data_bit |-> !dev_pull) else $error("device drove address bit");
    a_wr_data_quiet:
        assert property (hi && !rw_q && byten_q != 2'h0 && data_bit |-> !dev_pull) else $error("device drove write data");
    a_wr_ack_low:
        assert property (hi && acked_q && !rw_q && byten_q inside {2'h1, 2'h2} && last_bit |-> dev_pull)
            else $error("write byte not acknowledged");
    a_rd_ack_release:
        assert property (hi && rw_q && byten_q != 2'h0 && last_bit |-> !dev_pull) else $error("device held ack slot");
    a_mst_rd_ack:
        assert property (hi && rw_q && acked_q && byten_q == 2'h1 && last_bit |-> m_pull) else $error("master no ack");
    a_mst_rd_nack:
        assert property (hi && rw_q && byten_q == 2'h2 && last_bit |-> !m_pull) else $error("master acked last byte");
    a_foreign_quiet:
        assert property (hi && !acked_q && byten_q != 2'h0 |-> !dev_pull) else $error("device drove after nack");
    a_start_quiet:
        assert property (start |=> !dev_pull [*8]) else $error("device drove after start");
    a_stop_quiet:
        assert property (stop |=> !dev_pull [*8]) else $error("device drove after stop");
    a_scl_period:
        assert property (rise |-> per_q >= min_per) else $error("clock period too short");
    c_write_acked: cover property (hi && acked_q && !rw_q && byten_q == 2'h2 && last_bit);
    c_read_done: cover property (hi && rw_q && byten_q == 2'h2 && last_bit);
    c_addr_refused: cover property (hi && !acked_q && byten_q == 2'h1);
endmodule : adi_asserts

// [bench/amp_diag_i2c_slave_tb.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
        errors++; \
        $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
end
module amp_diag_i2c_slave_tb;
    logic clk, nrst, power_down_pin, bus_en_pin, diag_done_in, short_prot_in, clip_event_lo, clip_event_hi;
    logic [1:0] addr_pins, req_addr, fa;
    logic [7:0] diag_one_in, diag_two_in, instruction_byte_one, instruction_byte_two, wr_byte_one, wr_byte_two;
    logic clip_flag_output, turnon_diag_run, perm_diag_run, offset_det_run;
    logic req, req_read, busy, done, nack;
    logic [7:0] rd_byte_one, rd_byte_two, b1, b2, e1, e2;
    logic [31:0] r;
    int errors, tests_run, seed;
    adi_bus_if bus_i ();
    adi_device i_adi_device (.clk(clk), .nrst(nrst), .power_down_pin(power_down_pin), .bus_en_pin(bus_en_pin),
        .addr_pins(addr_pins), .diag_one_in(diag_one_in), .diag_two_in(diag_two_in), .diag_done_in(diag_done_in),
        .short_prot_in(short_prot_in), .clip_event_lo(clip_event_lo), .clip_event_hi(clip_event_hi),
        .instruction_byte_one(instruction_byte_one), .instruction_byte_two(instruction_byte_two),
        .clip_flag_output(clip_flag_output), .turnon_diag_run(turnon_diag_run), .perm_diag_run(perm_diag_run),
        .offset_det_run(offset_det_run), .bus(bus_i));
    adi_master i_adi_master (.clk(clk), .nrst(nrst), .req(req), .req_read(req_read), .req_addr(req_addr),
        .wr_byte_one(wr_byte_one), .wr_byte_two(wr_byte_two), .busy(busy), .done(done), .nack(nack),
        .rd_byte_one(rd_byte_one), .rd_byte_two(rd_byte_two), .bus(bus_i));
    adi_asserts i_adi_asserts (.clk(clk), .nrst(nrst), .scl_o(bus_i.scl_o), .scl_oe(bus_i.scl_oe),
        .sda_m_o(bus_i.sda_m_o), .sda_m_oe(bus_i.sda_m_oe), .sda_s_o(bus_i.sda_s_o), .sda_s_oe(bus_i.sda_s_oe),
        .scl(bus_i.scl), .sda(bus_i.sda));
    ////////////////////////////////////////////////////////////////
    function automatic logic [2:0] exp_runs(input logic [7:0] v1, input logic [7:0] v2, input logic sh);
        logic run;
        run = v2[adi_pkg::ib2_run_pos];
        return {v1[adi_pkg::ib1_diag_pos] && !run, run && sh,
            run && v1[adi_pkg::ib1_offset_pos] && v1[adi_pkg::ib1_unmute_pos]};
    endfunction : exp_runs
    task automatic end_sim();
        if (errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // called just after a falling edge; returns once done has been seen
    task automatic xfer(input logic rd, input logic [1:0] adr, input logic [7:0] v1, input logic [7:0] v2);
        int n;
        req_read = rd;
        req_addr = adr;
        wr_byte_one = v1;
        wr_byte_two = v2;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        `CHK("busy", 1'b1, busy)
        n = 0;
        while (done !== 1'b1 && n < 30000) begin
            @(negedge clk);
            n++;
        end
        `CHK("done", 1'b1, done)
        `CHK("idle", 1'b0, busy)
    endtask : xfer
    task automatic chk_write(input logic [7:0] v1, input logic [7:0] v2);
        logic [2:0] runs;
        xfer(1'b0, addr_pins, v1, v2);
        runs = exp_runs(v1, v2, short_prot_in);
        `CHK("nack", 1'b0, nack)
        repeat (6) @(negedge clk);
        `CHK("ib1", v1, instruction_byte_one)
        `CHK("ib2", v2, instruction_byte_two)
        `CHK("turnon", runs[2], turnon_diag_run)
        `CHK("perm", runs[1], perm_diag_run)
        `CHK("offset", runs[0], offset_det_run)
        for (int k = 0; k < 4; k++) begin
            {clip_event_hi, clip_event_lo} = 2'(k);
            repeat (6) @(negedge clk);
            `CHK("clip", v1[adi_pkg::ib1_clip_pos] ? clip_event_hi : clip_event_lo, clip_flag_output)
        end
    endtask : chk_write
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        end_sim();
    end
    initial begin
        errors = 0;
        tests_run = 0;
        seed = 32'h938c6bac;
        nrst = 1'b0;
        {req, req_read} = 2'h0;
        power_down_pin = 1'b1;
        bus_en_pin = 1'b1;
        {diag_done_in, short_prot_in, clip_event_lo, clip_event_hi} = 4'h0;
        req_addr = 2'h0;
        wr_byte_one = 8'h00;
        wr_byte_two = 8'h00;
        r = $random(seed);
        addr_pins = r[1:0];
        diag_one_in = r[15:8];
        diag_two_in = r[23:16];
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        // standby with turn-on diag, then play with offset detect and a short
        for (int i = 0; i < 2; i++) begin
            r = $random(seed);
            short_prot_in = i[0];
            b1 = r[7:0] | 8'h40 | {2'h0, i[0], 2'h0, i[0], 1'b0, i[0]};
            b1[0] = i[0];
            b2 = r[15:8];
            b2[4] = i[0];
            chk_write(b1, b2);
        end
        r = $random(seed);
        diag_one_in = r[7:0];
        diag_two_in = r[15:8];
        diag_done_in = r[16];
        // bit 5 of both bytes and bit 6 of the second are don't-care, so masked
        e1 = {diag_one_in[7], diag_done_in, 1'b0, b2[adi_pkg::ib2_run_pos], diag_one_in[3:0]};
        e2 = {b1[adi_pkg::ib1_offset_pos] && b1[adi_pkg::ib1_unmute_pos] && b2[adi_pkg::ib2_run_pos], 2'h0,
            b2[adi_pkg::ib2_run_pos], diag_two_in[3:0]};
        xfer(1'b1, addr_pins, 8'h00, 8'h00);
        `CHK("rd_nack", 1'b0, nack)
        `CHK("rd1", e1, rd_byte_one & 8'hdf)
        `CHK("rd2", e2, rd_byte_two & 8'h9f)
        fa = addr_pins ^ (r[20] ? 2'h3 : (r[21] ? 2'h1 : 2'h2));
        xfer(1'b0, fa, ~b1, ~b2);
        `CHK("foreign_nack", 1'b1, nack)
        `CHK("foreign_ib1", b1, instruction_byte_one)
        bus_en_pin = 1'b0;
        repeat (6) @(negedge clk);
        xfer(1'b0, addr_pins, ~b1, ~b2);
        `CHK("off_nack", 1'b1, nack)
        `CHK("off_ib2", b2, instruction_byte_two)
        bus_en_pin = 1'b1;
        power_down_pin = 1'b0;
        repeat (6) @(negedge clk);
        xfer(1'b0, addr_pins, ~b1, ~b2);
        `CHK("pd_nack", 1'b1, nack)
        `CHK("pd_ib2", adi_pkg::ib_reset, instruction_byte_two)
        end_sim();
    end
endmodule : amp_diag_i2c_slave_tb

// [common/adi_bus_if.sv]
`timescale 1ns/10ps
interface adi_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire logic scl = !(scl_oe && !scl_o);
    wire logic sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
    modport device (output sda_s_o, sda_s_oe, input scl, sda);
endinterface : adi_bus_if

// [common/adi_pkg.sv]
package adi_pkg;
    // address 11010 b a
    localparam logic [4:0] dev_addr_hi = 5'h1a;
    localparam int addr_shift_pos = 2;
    localparam int rw_pos = 0;
    // instruction byte one fields
    localparam int ib1_clip_pos = 0;
    localparam int ib1_unmute_pos = 2;
    localparam int ib1_gain_pos = 4;
    localparam int ib1_offset_pos = 5;
    localparam int ib1_diag_pos = 6;
    // instruction byte two fields
    localparam int ib2_hieff_pos = 1;
    localparam int ib2_line_pos = 3;
    localparam int ib2_run_pos = 4;
    // diagnostic byte fields
    localparam int db1_done_pos = 6;
    localparam int db_perm_pos = 4;
    localparam int db2_offset_pos = 7;
    localparam logic [7:0] ib_reset = 8'h00;
    localparam int bit_count = 8;
    // bus timing: 400 kHz max, master divider at 200 MHz
    localparam int clk_mhz = 200;
    localparam int scl_khz = 400;
    localparam int quarter_cycles = (clk_mhz * 1000 + 4 * scl_khz - 1) / (4 * scl_khz);
endpackage : adi_pkg

// [hdl/adi_device.sv]
`timescale 1ns/10ps
module adi_device (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pins
    input wire logic power_down_pin,
    input wire logic bus_en_pin,
    input wire logic [1:0] addr_pins,
    // diagnostic sources
    input wire logic [7:0] diag_one_in,
    input wire logic [7:0] diag_two_in,
    input wire logic diag_done_in,
    input wire logic short_prot_in,
    input wire logic clip_event_lo,
    input wire logic clip_event_hi,
    // settings out
    output logic [7:0] instruction_byte_one,
    output logic [7:0] instruction_byte_two,
    output logic clip_flag_output,
    output logic turnon_diag_run,
    output logic perm_diag_run,
    output logic offset_det_run,
    // bus
    adi_bus_if.device bus
);
    typedef enum logic [2:0] {st_idle, st_addr, st_ack, st_wr, st_rd, st_rdack, st_ignore} adi_dev_state_t;
    adi_dev_state_t state_q;
    logic scl_s, sda_s, pd_s, en_s, scl_p_q, sda_p_q;
    logic [7:0] sh_q, dbuf_q;
    logic [3:0] cnt_q;
    logic [1:0] idx_q;
    logic rw_q, drive_q, sda_oe_q;
    logic [7:0] diag1_q, diag2_q;
    logic [1:0] addr_q;

    adi_sync2 u_scl (.clk(clk), .nrst(nrst), .d(bus.scl), .q(scl_s));
    adi_sync2 u_sda (.clk(clk), .nrst(nrst), .d(bus.sda), .q(sda_s));
    adi_sync2 u_pd (.clk(clk), .nrst(nrst), .d(power_down_pin), .q(pd_s));
    adi_sync2 u_en (.clk(clk), .nrst(nrst), .d(bus_en_pin), .q(en_s));

    ////////////////////////////////////////////////////////////////////////
    wire active = pd_s && en_s;
    wire scl_rise = scl_s && !scl_p_q;
    wire scl_fall = !scl_s && scl_p_q;
    wire start_cond = scl_s && scl_p_q && sda_p_q && !sda_s;
    wire stop_cond = scl_s && scl_p_q && !sda_p_q && sda_s;
    wire [7:0] sh_next = {sh_q[6:0], sda_s};
    wire byte_done = scl_rise && (cnt_q == 4'(adi_pkg::bit_count - 1));
    wire addr_match = sh_next[7:3] == adi_pkg::dev_addr_hi && sh_next[2:1] == addr_q;
    wire standby = !instruction_byte_two[adi_pkg::ib2_run_pos];
    wire playing = instruction_byte_one[adi_pkg::ib1_unmute_pos];
    wire [7:0] db_sel = idx_q[0] ? diag2_q : diag1_q;
    // a read byte already went out, so the master owned this ack slot
    wire rd_more = rw_q && idx_q != 2'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            addr_q <= 2'h0;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            addr_q <= addr_pins;
        end
    end

    // snapshot of diagnostics taken when address byte completes, so a read is coherent
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            diag1_q <= 8'h00;
            diag2_q <= 8'h00;
        end else if (state_q == st_addr && byte_done) begin
            diag1_q <= {diag_one_in[7], diag_done_in, 1'b0, !standby, diag_one_in[3:0]};
            diag2_q <= {offset_det_run, 2'h0, !standby, diag_two_in[3:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= st_idle;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            idx_q <= 2'h0;
            rw_q <= 1'b0;
            drive_q <= 1'b0;
            dbuf_q <= 8'h00;
        end else if (!active || stop_cond) begin
            state_q <= st_idle;
            drive_q <= 1'b0;
        end else if (start_cond) begin
            state_q <= st_addr;
            cnt_q <= 4'h0;
            idx_q <= 2'h0;
            drive_q <= 1'b0;
        end else begin
            unique case (state_q)
                st_idle, st_ignore: drive_q <= 1'b0;
                st_addr, st_wr: begin
                    if (scl_rise) begin
                        sh_q <= sh_next;
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        cnt_q <= 4'h0;
                        if (state_q == st_addr) begin
                            rw_q <= sh_next[adi_pkg::rw_pos];
                            state_q <= addr_match ? st_ack : st_ignore;
                        end else begin
                            idx_q <= idx_q + 2'h1;
                            state_q <= (idx_q < 2'h2) ? st_ack : st_ignore;
                        end
                    end
                end
                st_ack: begin
                    if (scl_fall && !drive_q && !rd_more) begin
                        drive_q <= 1'b1; // low for whole ninth pulse
                        dbuf_q <= 8'h00;
                    end else if (scl_fall) begin
                        drive_q <= 1'b0;
                        if (rw_q) begin
                            dbuf_q <= db_sel;
                            drive_q <= !db_sel[7]; // changed while scl low
                            state_q <= st_rd;
                            idx_q <= idx_q + 2'h1;
                        end else begin
                            state_q <= st_wr;
                        end
                    end
                end
                st_rd: begin
                    if (scl_fall) begin
                        cnt_q <= cnt_q + 4'h1;
                        dbuf_q <= {dbuf_q[6:0], 1'b0};
                        drive_q <= !dbuf_q[6] && cnt_q != 4'(adi_pkg::bit_count - 1);
                        if (cnt_q == 4'(adi_pkg::bit_count - 1)) begin
                            cnt_q <= 4'h0;
                            state_q <= st_rdack;
                        end
                    end
                end
                st_rdack: begin
                    if (scl_rise) begin
                        // master ack low means continue; nack or both bytes sent ends
                        state_q <= (!sda_s && idx_q < 2'h2) ? st_ack : st_ignore;
                        drive_q <= 1'b0;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            instruction_byte_one <= adi_pkg::ib_reset;
            instruction_byte_two <= adi_pkg::ib_reset;
        end else if (!pd_s) begin
            instruction_byte_two <= adi_pkg::ib_reset; // standby
        end else if (state_q == st_wr && byte_done && idx_q < 2'h2) begin
            if (idx_q == 2'h0) begin
                instruction_byte_one <= sh_next;
            end else begin
                instruction_byte_two <= sh_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sda_oe_q <= 1'b0;
            clip_flag_output <= 1'b0;
            turnon_diag_run <= 1'b0;
            perm_diag_run <= 1'b0;
            offset_det_run <= 1'b0;
        end else begin
            sda_oe_q <= drive_q;
            clip_flag_output <= instruction_byte_one[adi_pkg::ib1_clip_pos] ? clip_event_hi : clip_event_lo;
            turnon_diag_run <= instruction_byte_one[adi_pkg::ib1_diag_pos] && standby;
            perm_diag_run <= !standby && short_prot_in;
            offset_det_run <= instruction_byte_one[adi_pkg::ib1_offset_pos] && !standby && playing;
        end
    end

    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = sda_oe_q;
endmodule : adi_device

// [hdl/adi_master.sv]
`timescale 1ns/10ps
module adi_master (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // request
    input wire logic req,
    input wire logic req_read,
    input wire logic [1:0] req_addr,
    input wire logic [7:0] wr_byte_one,
    input wire logic [7:0] wr_byte_two,
    // answer
    output logic busy,
    output logic done,
    output logic nack,
    output logic [7:0] rd_byte_one,
    output logic [7:0] rd_byte_two,
    // bus
    adi_bus_if.master bus
);
    typedef enum logic [2:0] {m_idle, m_start, m_bit, m_stop, m_end} adi_mst_state_t;
    adi_mst_state_t state_q;
    logic [15:0] div_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] tx_q, rx_q;
    logic scl_q, sda_q, rd_q, sda_s, nack_q;
    logic [7:0] b1_q, b2_q;

    adi_sync2 u_sda (.clk(clk), .nrst(nrst), .d(bus.sda), .q(sda_s));

    // quarter-period tick keeps scl at 400 kHz or below
    wire tick = div_q == 16'(adi_pkg::quarter_cycles - 1);
    wire ack_slot = bit_q == 4'(adi_pkg::bit_count);
    wire last_byte = byte_q == 2'h2;
    wire [7:0] next_tx = byte_q == 2'h0 ? wr_byte_one : wr_byte_two;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= (tick || state_q == m_idle) ? 16'h0000 : div_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= m_idle;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rd_q <= 1'b0;
            nack_q <= 1'b0;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_q)
                m_idle: if (req) begin
                    busy <= 1'b1;
                    rd_q <= req_read;
                    nack_q <= 1'b0;
                    tx_q <= {adi_pkg::dev_addr_hi, req_addr, req_read};
                    state_q <= m_start;
                    ph_q <= 2'h0;
                end
                m_start: if (tick) begin
                    sda_q <= 1'b0; // falls while scl high
                    state_q <= m_bit;
                    bit_q <= 4'h0;
                    byte_q <= 2'h0;
                    ph_q <= 2'h0;
                end
                m_bit: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    unique case (ph_q)
                        2'h0: begin
                            scl_q <= 1'b0;
                        end
                        2'h1: begin
                            // data set while scl low
                            if (ack_slot) begin
                                sda_q <= (rd_q && byte_q != 2'h0) ? last_byte : 1'b1;
                            end else if (rd_q && byte_q != 2'h0) begin
                                sda_q <= 1'b1;
                            end else begin
                                sda_q <= tx_q[7];
                            end
                        end
                        2'h2: begin
                            scl_q <= 1'b1; // sda unchanged until next low phase
                        end
                        2'h3: begin
                            if (ack_slot) begin
                                bit_q <= 4'h0;
                                if (!(rd_q && byte_q != 2'h0) && sda_s) begin
                                    nack_q <= 1'b1;
                                end
                                if (byte_q == 2'h1) begin
                                    b1_q <= rx_q;
                                end else if (byte_q == 2'h2) begin
                                    b2_q <= rx_q;
                                end
                                if (last_byte || (!(rd_q && byte_q != 2'h0) && sda_s)) begin
                                    state_q <= m_stop;
                                    ph_q <= 2'h0;
                                end
                                byte_q <= byte_q + 2'h1;
                                tx_q <= next_tx;
                            end else begin
                                rx_q <= {rx_q[6:0], sda_s};
                                tx_q <= {tx_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                        default: ph_q <= 2'h0;
                    endcase
                end
                m_stop: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    unique case (ph_q)
                        2'h0: scl_q <= 1'b0;
                        2'h1: sda_q <= 1'b0;
                        2'h2: scl_q <= 1'b1;
                        2'h3: begin
                            sda_q <= 1'b1; // rises while scl high
                            state_q <= m_end;
                        end
                        default: ph_q <= 2'h0;
                    endcase
                end
                m_end: if (tick) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    state_q <= m_idle;
                end
                default: state_q <= m_idle;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nack <= 1'b0;
            rd_byte_one <= 8'h00;
            rd_byte_two <= 8'h00;
        end else if (state_q == m_end && tick) begin
            nack <= nack_q;
            rd_byte_one <= b1_q;
            rd_byte_two <= b2_q;
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = !scl_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = !sda_q;
endmodule : adi_master

// [hdl/adi_sync2.sv]
`timescale 1ns/10ps
module adi_sync2 (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // level
    input wire logic d,
    output logic q
);
    logic meta_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : adi_sync2
